// ==== verilog/dll_switch_sequencer.sv ====
// controller side sequencer switching a DDR3 device between DLL-on and DLL-off
// Functional notes
// RQ1: device keeps DLL off while MR1 bit A0 is one.
// RQ2: before the DLL-off write, all banks precharged and ODT low.
// RQ3: wait tMOD after DLL-off write, enter self refresh, wait tCKSRE.
// RQ4: stable clock for tCKSRX after frequency change before self refresh exit.
// RQ5: off path keeps CKE high from exit until last tMOD has passed.
// RQ6: ODT held low from self refresh exit through the wait.
// RQ7: off path waits tXS, writes CL, CWL, WR, optional long ZQ, tMOD.
// RQ8: on path precharges all banks with ODT low before self refresh.
// RQ9: on path keeps CKE high and ODT low until tDLLK after DLL reset.
// RQ10: on path waits tXS then clears MR1 bit A0.
// RQ11: tMRD later, write MR0 with bit A8 set to reset the DLL.
// RQ12: tMRD later, reprogram mode registers; long ZQ after tMOD.
// RQ13: wait tMOD, tDLLK and tZQoper before finishing.
// RQ14: every wait counts real clock edges between commands.
// RQ15: nanosecond times become cycles by rounding up.
// RQ16: off path programs CL 6 and CWL 6 exactly.
// RQ17: device starts read strobes one cycle earlier with DLL off.
// RQ18: every wait is a configurable count; steps advance on expiry.
module dll_switch_sequencer
    import dll_switch_pkg::*;
#(
    parameter int unsigned T_MOD = dll_switch_pkg::T_MOD_NCK,
    parameter int unsigned T_MRD = dll_switch_pkg::T_MRD_NCK,
    parameter int unsigned T_RP = dll_switch_pkg::T_RP_CYC,
    parameter int unsigned T_XS = dll_switch_pkg::T_XS_CYC,
    parameter int unsigned T_CKSRE = dll_switch_pkg::T_CKSRE_NCK,
    parameter int unsigned T_CKSRX = dll_switch_pkg::T_CKSRX_NCK,
    parameter int unsigned T_DLLK = dll_switch_pkg::T_DLLK_NCK,
    parameter int unsigned T_ZQOPER = dll_switch_pkg::T_ZQOPER_NCK
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic start,
    input wire logic toDllOff,
    input wire logic zqLong,
    input wire logic odtReq,
    input wire logic [13:0] mr0Val,
    input wire logic [13:0] mr2Val,
    input wire logic clkStableIn,
    output dll_switch_pkg::ddr_bus_t ddr,
    output logic freqChangeReq,
    output logic busy,
    output logic done,
    output logic dllDisabled
);
    import dll_switch_pkg::*;

    // =====================================================================
    // parameter checks
    localparam int unsigned TMAX = (1 << TIMER_W) - 1;
    if (T_MOD < 1 || T_MRD < 1 || T_RP < 1 || T_XS < 1 || T_CKSRE < 1 || T_CKSRX < 1 ||
        T_DLLK < 1 || T_ZQOPER < 1 || T_MOD > TMAX || T_MRD > TMAX || T_RP > TMAX ||
        T_XS > TMAX || T_CKSRE > TMAX || T_CKSRX > TMAX || T_DLLK > TMAX || T_ZQOPER > TMAX) begin : g_bad
        $error("wait counts must lie between 1 and the timer range");
    end

    typedef enum {
        ST_IDLE, ST_PREA, ST_MR1_OFF, ST_SRE, ST_FREQ_DROP, ST_FREQ_RISE, ST_SRX,
        ST_MR1_ON, ST_DLL_RESET, ST_MR2, ST_MR0, ST_ZQ, ST_WAIT, ST_LOCK_WAIT
    } state_t;

    state_t state, resume;
    logic goOff, doZq;
    logic [13:0] mr0Hold, mr2Hold;
    logic stableMeta, stable;
    logic waitLoad, waitDone, lockDone;
    logic [TIMER_W-1:0] waitLen;

    // length of the wait that follows the command issued in a state
    function automatic logic [TIMER_W-1:0] waitFor(input state_t s, input logic off);
        unique case (s)
            ST_PREA: return TIMER_W'(T_RP);
            ST_MR1_OFF: return TIMER_W'(T_MOD);
            ST_SRE: return TIMER_W'(T_CKSRE);
            ST_FREQ_RISE: return TIMER_W'(T_CKSRX);
            ST_SRX: return TIMER_W'(T_XS);
            ST_MR1_ON, ST_DLL_RESET: return TIMER_W'(T_MRD);
            ST_MR2: return off ? TIMER_W'(T_MRD) : TIMER_W'(T_MOD);
            ST_MR0: return TIMER_W'(T_MOD);
            ST_ZQ: return TIMER_W'(T_ZQOPER);
            ST_IDLE, ST_FREQ_DROP, ST_WAIT, ST_LOCK_WAIT: return TIMER_W'(0);
        endcase
    endfunction

    // =====================================================================
    // clock-stable pin crosses in through two flops
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stableMeta <= 1'b0;
            stable <= 1'b0;
        end else begin
            stableMeta <= clkStableIn;
            stable <= stableMeta;
        end
    end

    // =====================================================================
    // timers: one for the step waits, one for DLL relock
    always_comb begin
        waitLen = waitFor(state, goOff);
        waitLoad = (waitLen != '0) && (state != ST_WAIT);
    end

    dram_wait_timer #(.W(TIMER_W)) u_step_timer (
        .clk(clk),
        .reset_n(reset_n),
        .load(waitLoad),
        .length(waitLen),
        .expired(waitDone)
    );

    dram_wait_timer #(.W(TIMER_W)) u_lock_timer (
        .clk(clk),
        .reset_n(reset_n),
        .load(state == ST_DLL_RESET),
        .length(TIMER_W'(T_DLLK)),
        .expired(lockDone)
    );

    // =====================================================================
    // sequence control; a step leaves a wait only when its timer expires
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_IDLE;
            resume <= ST_IDLE;
            goOff <= 1'b0;
            doZq <= 1'b0;
            mr0Hold <= '0;
            mr2Hold <= '0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (start) begin
                        goOff <= toDllOff;
                        doZq <= zqLong;
                        mr0Hold <= mr0Val;
                        mr2Hold <= mr2Val;
                        state <= ST_PREA; // RQ2 RQ8
                    end
                end
                ST_PREA: begin
                    resume <= goOff ? ST_MR1_OFF : ST_SRE;
                    state <= ST_WAIT;
                end
                ST_MR1_OFF: begin
                    resume <= ST_SRE; // RQ3
                    state <= ST_WAIT;
                end
                ST_SRE: begin
                    resume <= ST_FREQ_DROP; // RQ3
                    state <= ST_WAIT;
                end
                ST_FREQ_DROP: begin
                    if (!stable) begin
                        state <= ST_FREQ_RISE;
                    end
                end
                ST_FREQ_RISE: begin
                    if (stable) begin
                        resume <= ST_SRX; // RQ4
                        state <= ST_WAIT;
                    end
                end
                ST_SRX: begin
                    resume <= goOff ? ST_MR2 : ST_MR1_ON; // RQ7 RQ10
                    state <= ST_WAIT;
                end
                ST_MR1_ON: begin
                    resume <= ST_DLL_RESET; // RQ11
                    state <= ST_WAIT;
                end
                ST_DLL_RESET: begin
                    resume <= ST_MR2; // RQ12
                    state <= ST_WAIT;
                end
                ST_MR2: begin
                    resume <= goOff ? ST_MR0 : (doZq ? ST_ZQ : ST_LOCK_WAIT);
                    state <= ST_WAIT;
                end
                ST_MR0: begin
                    resume <= doZq ? ST_ZQ : ST_LOCK_WAIT; // RQ7
                    state <= ST_WAIT;
                end
                ST_ZQ: begin
                    resume <= ST_LOCK_WAIT; // RQ13
                    state <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (waitDone) begin
                        state <= resume; // RQ14 RQ18
                    end
                end
                ST_LOCK_WAIT: begin
                    if (lockDone) begin
                        state <= ST_IDLE; // RQ13
                    end
                end
            endcase
        end
    end

    // =====================================================================
    // command bus; odt held low all sequence long, which suits both termination settings
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ddr <= BUS_RESET;
        end else begin
            ddr.cmd <= CMD_NOP;
            ddr.odt <= (state == ST_IDLE) ? odtReq : 1'b0; // RQ6 RQ9
            unique case (state)
                ST_PREA: begin
                    ddr.cmd <= CMD_PRE;
                    ddr.addr <= 14'h0400; // RQ2 RQ8
                end
                ST_MR1_OFF: begin
                    ddr.cmd <= CMD_MRS;
                    ddr.ba <= BA_MR1;
                    ddr.addr <= 14'h0001; // RQ3
                end
                ST_SRE: begin
                    ddr.cmd <= CMD_REF;
                    ddr.cke <= 1'b0;
                end
                ST_SRX: begin
                    ddr.cke <= 1'b1; // RQ5 RQ9
                end
                ST_MR1_ON: begin
                    ddr.cmd <= CMD_MRS;
                    ddr.ba <= BA_MR1;
                    ddr.addr <= 14'h0000; // RQ10
                end
                ST_DLL_RESET: begin
                    ddr.cmd <= CMD_MRS;
                    ddr.ba <= BA_MR0;
                    ddr.addr <= mr0Hold | 14'h0100; // RQ11
                end
                ST_MR2: begin
                    ddr.cmd <= CMD_MRS;
                    ddr.ba <= BA_MR2;
                    ddr.addr <= goOff ? ((mr2Hold & ~MR2_CWL_MASK) | MR2_CWL6) : mr2Hold; // RQ16
                end
                ST_MR0: begin
                    ddr.cmd <= CMD_MRS;
                    ddr.ba <= BA_MR0;
                    ddr.addr <= (mr0Hold & ~MR0_CL_MASK & 14'h3EFF) | MR0_CL6; // RQ16
                end
                ST_ZQ: begin
                    ddr.cmd <= CMD_ZQ;
                    ddr.addr <= 14'h0400; // RQ7 RQ12
                end
                ST_IDLE, ST_FREQ_DROP, ST_FREQ_RISE, ST_WAIT, ST_LOCK_WAIT: ;
            endcase
        end
    end

    // =====================================================================
    // status toward the user
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            freqChangeReq <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            dllDisabled <= 1'b0;
        end else begin
            freqChangeReq <= (state == ST_FREQ_DROP) || (state == ST_FREQ_RISE && !stable);
            busy <= (state != ST_IDLE) || start;
            done <= (state == ST_LOCK_WAIT) && lockDone;
            if (state == ST_MR1_OFF) begin
                dllDisabled <= 1'b1; // RQ1
            end else if (state == ST_MR1_ON) begin
                dllDisabled <= 1'b0;
            end
        end
    end

    // =====================================================================
    // checks: spacing counter between command events seen on the bus
    logic prevCke, isCmd, afterSrx, lastMrs;
    logic [TIMER_W-1:0] sinceCmd;
    assign isCmd = (ddr.cmd != CMD_NOP) || (ddr.cke != prevCke);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prevCke <= 1'b1;
            sinceCmd <= '1;
            afterSrx <= 1'b0;
            lastMrs <= 1'b0;
        end else begin
            prevCke <= ddr.cke;
            if (isCmd) begin
                sinceCmd <= TIMER_W'(1);
                afterSrx <= ddr.cke && !prevCke;
                lastMrs <= (ddr.cmd == CMD_MRS);
            end else if (sinceCmd != '1) begin
                sinceCmd <= sinceCmd + TIMER_W'(1);
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    AST_ODT_LOW_AT_DLL_OFF: assert property ( // RQ2
        (ddr.cmd == CMD_MRS && ddr.ba == BA_MR1 && ddr.addr[DLL_OFF_BIT]) |-> !ddr.odt && lastMrs == 1'b0)
        else $error("DLL-off write without idle precharged device");
    AST_SRE_AFTER_MOD: assert property ( // RQ3
        ($fell(ddr.cke) && goOff) |-> sinceCmd >= TIMER_W'(T_MOD) && ddr.cmd == CMD_REF)
        else $error("self refresh entered before tMOD");
    AST_SRX_AFTER_CKSRX: assert property ( // RQ4
        $rose(ddr.cke) |-> $past(stable, T_CKSRX))
        else $error("self refresh exit before tCKSRX");
    AST_CKE_HELD_HIGH: assert property ( // RQ5
        $fell(ddr.cke) |-> $past(state) == ST_SRE && ddr.cmd == CMD_REF)
        else $error("CKE dropped before sequence end");
    AST_ODT_LOW_BUSY: assert property ( // RQ6
        (busy && $past(busy)) |-> !ddr.odt)
        else $error("ODT high during sequence");
    AST_XS_BEFORE_MRS: assert property ( // RQ7
        (isCmd && afterSrx) |-> sinceCmd >= TIMER_W'(T_XS) && ddr.cmd == CMD_MRS)
        else $error("mode register write before tXS");
    AST_MRD_SPACING: assert property ( // RQ12
        (ddr.cmd == CMD_MRS && lastMrs) |-> sinceCmd >= TIMER_W'(T_MRD))
        else $error("mode register writes closer than tMRD");
    AST_DLL_RESET_BIT: assert property ( // RQ11
        (ddr.cmd == CMD_MRS && ddr.ba == BA_MR0 && !goOff) |-> ddr.addr[DLL_RESET_BIT])
        else $error("DLL reset bit missing on MR0 write");
    AST_CWL_SIX_OFF: assert property ( // RQ16
        (ddr.cmd == CMD_MRS && ddr.ba == BA_MR2 && goOff) |-> (ddr.addr & MR2_CWL_MASK) == MR2_CWL6)
        else $error("DLL-off path without CWL 6");
    AST_DONE_AFTER_LOCK: assert property ( // RQ13
        done |-> $past(lockDone) && (!doZq || sinceCmd >= TIMER_W'(T_ZQOPER)))
        else $error("done before DLL lock time");

    COV_SWITCH_OFF: cover property (start && toDllOff && state == ST_IDLE ##[1:1000] done);
    COV_SWITCH_ON_ZQ: cover property ((ddr.cmd == CMD_ZQ) && !goOff);
    COV_DLL_RESET: cover property (ddr.cmd == CMD_MRS && ddr.addr[DLL_RESET_BIT] && !goOff);
endmodule

// ==== verilog/dll_switch_pkg.sv ====
// constants and types shared by the DLL on/off switch sequencer
package dll_switch_pkg;
    // =====================================================================
    // clock and timing
    localparam int unsigned CLK_PERIOD_PS = 10000;
    localparam int unsigned TIMER_W = 12;
    localparam int unsigned T_MOD_NCK = 12;
    localparam int unsigned T_MRD_NCK = 4;
    localparam int unsigned T_CKSRE_NCK = 5;
    localparam int unsigned T_CKSRX_NCK = 5;
    localparam int unsigned T_DLLK_NCK = 512;
    localparam int unsigned T_ZQOPER_NCK = 256;
    localparam int unsigned T_XS_NS = 170;
    localparam int unsigned T_RP_NS = 14;

    // nanoseconds to whole cycles, rounded up, never below one
    function automatic int unsigned nsToCycles(input int unsigned ns);
        int unsigned cyc;
        cyc = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (cyc < 1) ? 1 : cyc;
    endfunction

    localparam int unsigned T_XS_CYC = nsToCycles(T_XS_NS); // RQ15
    localparam int unsigned T_RP_CYC = nsToCycles(T_RP_NS);

    // =====================================================================
    // mode register layout
    localparam logic [2:0] BA_MR0 = 3'h0;
    localparam logic [2:0] BA_MR1 = 3'h1;
    localparam logic [2:0] BA_MR2 = 3'h2;
    localparam int unsigned DLL_OFF_BIT = 0;
    localparam int unsigned DLL_RESET_BIT = 8;
    localparam int unsigned AP_BIT = 10;
    localparam logic [13:0] MR0_CL_MASK = 14'h0074;
    localparam logic [13:0] MR0_CL6 = 14'h0020;
    localparam logic [13:0] MR2_CWL_MASK = 14'h0038;
    localparam logic [13:0] MR2_CWL6 = 14'h0008;

    // =====================================================================
    // command bus
    typedef struct packed {
        logic csN;
        logic rasN;
        logic casN;
        logic weN;
    } cmd_t;

    localparam cmd_t CMD_NOP = 4'h7;
    localparam cmd_t CMD_MRS = 4'h0;
    localparam cmd_t CMD_REF = 4'h1;
    localparam cmd_t CMD_PRE = 4'h2;
    localparam cmd_t CMD_ZQ = 4'h6;

    typedef struct packed {
        logic cke;
        logic odt;
        cmd_t cmd;
        logic [2:0] ba;
        logic [13:0] addr;
    } ddr_bus_t;

    localparam ddr_bus_t BUS_RESET = '{cke: 1'b1, odt: 1'b0, cmd: CMD_NOP, ba: 3'h0, addr: 14'h0000};
endpackage

// ==== verilog/dram_wait_timer.sv ====
// down counter that measures one wait interval in clock edges
module dram_wait_timer #(
    parameter int unsigned W = 12
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic load,
    input wire logic [W-1:0] length,
    output logic expired
);
    logic [W-1:0] count;

    // =====================================================================
    // counter: a load of N reaches zero N-1 edges later
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count <= '0;
        end else if (load) begin
            count <= length - W'(1);
        end else if (count != '0) begin
            count <= count - W'(1);
        end
    end

    assign expired = (count == '0) && !load; // RQ18

    // =====================================================================
    // checks
    AST_TIMER_HOLDS: assert property (@(posedge clk) disable iff (!reset_n) // RQ18
        (load && length >= W'(3)) |=> !expired [*2])
        else $error("wait timer expired early");
    COV_TIMER_LONG: cover property (@(posedge clk) disable iff (!reset_n) load && length > W'(100));
endmodule

// ==== test/dram_dll_model.sv ====
// behavioural DDR3 device model: mode registers, self refresh and command spacing checks
module dram_dll_model
    import dll_switch_pkg::*;
#(
    parameter int unsigned T_MOD = 12,
    parameter int unsigned T_MRD = 4,
    parameter int unsigned T_RP = 2,
    parameter int unsigned T_XS = 17,
    parameter int unsigned T_ZQOPER = 256
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire dll_switch_pkg::ddr_bus_t ddr,
    output logic [13:0] mr0,
    output logic [13:0] mr1,
    output logic [13:0] mr2,
    output logic dllOff,
    output logic [4:0] cl,
    output logic [4:0] cwl,
    output logic [4:0] readLat,
    output logic [7:0] violations,
    output logic [31:0] edgeNow,
    output logic [31:0] resetEdge,
    output logic [31:0] zqEdge
);
    timeunit 1ns;
    timeprecision 1ps;
    typedef enum logic [1:0] {K_NONE, K_MRS, K_PRE, K_ZQ} kind_t;
    kind_t lastKind;
    logic [31:0] lastCmd;
    logic [31:0] exitEdge;
    logic [31:0] need;
    logic prevCke;
    logic idle;
    logic isCmd;
    logic fault;

    // =====================================================================
    // decoded mode register state
    assign dllOff = mr1[DLL_OFF_BIT];
    assign cl = {2'b00, mr0[6:4]} + 5'h4;
    assign cwl = {2'b00, mr2[5:3]} + 5'h5;
    // additive latency assumed zero; the strobe leads by one cycle with the DLL off
    assign readLat = dllOff ? cl - 5'h1 : cl;

    // =====================================================================
    // spacing owed since the previous command, counted in real edges
    always_comb begin
        case (lastKind)
            K_MRS: need = (ddr.cmd === CMD_MRS) ? T_MRD : T_MOD;
            K_PRE: need = T_RP;
            K_ZQ: need = T_ZQOPER;
            default: need = 32'h1;
        endcase
    end

    // breaches seen at this edge count once together, so each bad cycle adds exactly one
    always_comb begin
        isCmd = ddr.cmd !== CMD_NOP;
        fault = 1'b0;
        if (isCmd && edgeNow - lastCmd < need) fault = 1'b1;
        if (isCmd && exitEdge > lastCmd && edgeNow - exitEdge < T_XS) fault = 1'b1;
        if (ddr.cke === 1'b0 && ddr.odt !== 1'b0) fault = 1'b1;
        if (prevCke === 1'b0 && ddr.cke === 1'b0 && isCmd) fault = 1'b1;
        if (prevCke === 1'b1 && ddr.cke !== 1'b1 && ddr.cmd !== CMD_REF) fault = 1'b1;
        if (ddr.cmd === CMD_REF && !(idle && ddr.odt === 1'b0)) fault = 1'b1;
        if (ddr.cmd === CMD_MRS && ddr.ba === BA_MR1 && ddr.addr[0] && !idle) fault = 1'b1;
        if (ddr.cmd === CMD_ZQ && ddr.addr[AP_BIT] !== 1'b1) fault = 1'b1;
    end

    // command registration and edge bookkeeping
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            edgeNow <= '0;
            lastCmd <= '0;
            exitEdge <= '0;
            resetEdge <= '0;
            zqEdge <= '0;
            lastKind <= K_NONE;
            prevCke <= 1'b1;
            idle <= 1'b0;
            violations <= '0;
            mr0 <= '0;
            mr1 <= '0;
            mr2 <= '0;
        end else begin
            edgeNow <= edgeNow + 32'h1;
            prevCke <= ddr.cke;
            if (fault) violations <= violations + 8'h1;
            if (prevCke === 1'b0 && ddr.cke === 1'b1) begin
                exitEdge <= edgeNow;
                idle <= 1'b0;
            end
            if (isCmd) begin
                lastCmd <= edgeNow;
                lastKind <= K_NONE;
            end
            if (ddr.cmd === CMD_PRE) begin
                lastKind <= K_PRE;
                idle <= ddr.addr[AP_BIT];
            end
            if (ddr.cmd === CMD_ZQ) begin
                lastKind <= K_ZQ;
                zqEdge <= edgeNow;
            end
            if (ddr.cmd === CMD_MRS) begin
                lastKind <= K_MRS;
                case (ddr.ba)
                    BA_MR0: mr0 <= ddr.addr;
                    BA_MR1: mr1 <= ddr.addr;
                    BA_MR2: mr2 <= ddr.addr;
                    default: lastKind <= K_MRS;
                endcase
                if (ddr.ba === BA_MR0 && ddr.addr[DLL_RESET_BIT]) resetEdge <= edgeNow;
            end
        end
    end
endmodule

// ==== test/tb_dll_switch_sequencer.sv ====
// self-checking bench for the DLL on/off switch sequencer
module tb_dll_switch_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    import dll_switch_pkg::*;

    // short waits keep the run brief; every timing expectation derives from these
    localparam int unsigned TM = 6;
    localparam int unsigned TR = 3;
    localparam int unsigned TRP = 2;
    localparam int unsigned TXS = 5;
    localparam int unsigned TSE = 3;
    localparam int unsigned TSX = 4;
    localparam int unsigned TDL = 20;
    localparam int unsigned TZQ = 8;

    logic clk, reset_n, start, toDllOff, zqLong, odtReq, clkStableIn;
    logic [13:0] mr0Val, mr2Val, mr0, mr1, mr2;
    ddr_bus_t ddr;
    logic freqChangeReq, busy, done, dllDisabled, dllOff;
    logic [4:0] cl, cwl, readLat;
    logic [7:0] violations;
    logic [31:0] edgeNow, resetEdge, zqEdge;
    int failures, testsRun;

    dll_switch_sequencer #(.T_MOD(TM), .T_MRD(TR), .T_RP(TRP), .T_XS(TXS), .T_CKSRE(TSE), .T_CKSRX(TSX),
        .T_DLLK(TDL), .T_ZQOPER(TZQ)) dll_switch_sequencer_i (.clk(clk), .reset_n(reset_n), .start(start),
        .toDllOff(toDllOff), .zqLong(zqLong), .odtReq(odtReq), .mr0Val(mr0Val), .mr2Val(mr2Val),
        .clkStableIn(clkStableIn), .ddr(ddr), .freqChangeReq(freqChangeReq), .busy(busy), .done(done),
        .dllDisabled(dllDisabled));

    dram_dll_model #(.T_MOD(TM), .T_MRD(TR), .T_RP(TRP), .T_XS(TXS), .T_ZQOPER(TZQ)) dram_dll_model_i (
        .clk(clk), .reset_n(reset_n), .ddr(ddr), .mr0(mr0), .mr1(mr1), .mr2(mr2), .dllOff(dllOff), .cl(cl),
        .cwl(cwl), .readLat(readLat), .violations(violations), .edgeNow(edgeNow), .resetEdge(resetEdge),
        .zqEdge(zqEdge));

    // =====================================================================
    // compare, report and finish
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", testsRun, failures);
        if (failures == 0 && testsRun > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // =====================================================================
    // scenarios
    task automatic testResetValues();
        check("bus in reset", ddr, BUS_RESET);
        check("flags in reset", {freqChangeReq, busy, done, dllDisabled}, 4'h0);
        $display("test reset values finished");
    endtask

    // one full switch; a second start during the clock change must be ignored
    task automatic testSwitch(input logic off, input logic zq);
        logic [31:0] srAt, stableAt, exitAt, zqBefore;
        int t;
        logic bad;
        srAt = 0;
        bad = 1'b0;
        zqBefore = zqEdge;
        @(posedge clk);
        toDllOff <= off;
        zqLong <= zq;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        #1 check("busy after start", busy, 1'b1);
        t = 0;
        while (ddr.cmd !== CMD_PRE && t < 20) begin
            @(posedge clk);
            #1 t++;
        end
        check("precharge all", ddr.addr[AP_BIT], 1'b1);
        t = 0;
        while (freqChangeReq !== 1'b1 && t < 500) begin
            @(posedge clk);
            #1 t++;
            if (ddr.cke === 1'b0 && srAt == 0) srAt = edgeNow;
        end
        check("clock change wait", edgeNow - srAt >= TSE, 1'b1);
        @(posedge clk);
        start <= 1'b1;
        toDllOff <= ~off;
        @(posedge clk);
        start <= 1'b0;
        toDllOff <= off;
        repeat (6) @(posedge clk);
        #1 check("stays in self refresh", {ddr.cke, freqChangeReq}, 2'b01);
        @(posedge clk);
        clkStableIn <= 1'b0;
        repeat (4) @(posedge clk);
        clkStableIn <= 1'b1;
        #1 stableAt = edgeNow;
        t = 0;
        while (ddr.cke !== 1'b1 && t < 100) begin
            @(posedge clk);
            #1 t++;
        end
        exitAt = edgeNow;
        check("stable clock before exit", exitAt - stableAt > TSX + 2, 1'b1);
        check("clock change released", freqChangeReq, 1'b0);
        t = 0;
        while (done !== 1'b1 && t < 2000) begin
            @(posedge clk);
            #1 t++;
            if (ddr.cke !== 1'b1 || ddr.odt !== 1'b0) bad = 1'b1;
        end
        check("cke high odt low after exit", bad, 1'b0);
        check("device spacing faults", violations, 8'h0);
        check("device dll off", dllOff, off);
        check("host dll view", dllDisabled, off);
        if (zq) begin
            check("long calibration after exit", zqEdge > exitAt, 1'b1);
            check("calibration wait", edgeNow - zqEdge >= TZQ, 1'b1);
        end else begin
            check("no calibration", zqEdge, zqBefore);
        end
        if (off) begin
            check("cas latency", cl, 5'h6);
            check("cas write latency", cwl, 5'h6);
            check("read strobe latency", readLat, 5'h5);
            check("write recovery kept", mr0[11:9], mr0Val[11:9]);
        end else begin
            check("dll reset write", mr0, mr0Val | 14'h0100);
            check("lock wait", edgeNow - resetEdge >= TDL, 1'b1);
            check("mode register two", mr2, mr2Val);
            check("read latency dll on", readLat, cl);
        end
        @(posedge clk);
        #1 check("done one cycle", done, 1'b0);
        repeat (2) @(posedge clk);
        #1 check("idle odt follows request", {busy, ddr.odt}, {1'b0, odtReq});
        $display("test switch off=%0d zq=%0d finished", off, zq);
    endtask

    // =====================================================================
    // clock, watchdog and main sequence
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        $display("mismatch watchdog expected done seen timeout");
        results();
    end

    initial begin
        failures = 0;
        testsRun = 0;
        reset_n = 1'b0;
        start = 1'b0;
        toDllOff = 1'b0;
        zqLong = 1'b0;
        odtReq = 1'b1;
        mr0Val = 14'h0A10;
        mr2Val = 14'h0018;
        clkStableIn = 1'b1;
        repeat (11) @(posedge clk);
        #1 testResetValues();
        @(posedge clk);
        reset_n <= 1'b1;
        testSwitch(1'b1, 1'b1);
        testSwitch(1'b0, 1'b1);
        testSwitch(1'b1, 1'b0);
        testSwitch(1'b0, 1'b0);
        results();
    end
endmodule
